/* File: core/mpg_pkg.sv */
// package of constants and types for the multi-port parallel i/o block
`default_nettype none
package mpg_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned MPG_ADDR_W = 18;
    localparam int unsigned MPG_IDX_W = 16;
    localparam int unsigned MPG_BUS_W = 32;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [15:0] MPG_IDX_LATCH0 = 16'hff00;
    localparam logic [15:0] MPG_IDX_LATCH1 = 16'hff01;
    localparam logic [15:0] MPG_IDX_INPUT2 = 16'hff02;
    localparam logic [15:0] MPG_IDX_LATCH3 = 16'hff03;
    localparam logic [15:0] MPG_IDX_LATCH6 = 16'hff06;
    localparam logic [15:0] MPG_IDX_LATCH7 = 16'hff07;
    localparam logic [15:0] MPG_IDX_LATCH12 = 16'hff0c;
    localparam logic [15:0] MPG_IDX_LATCH13 = 16'hff0d;
    localparam logic [15:0] MPG_IDX_DIR0 = 16'hff20;
    localparam logic [15:0] MPG_IDX_DIR1 = 16'hff21;
    localparam logic [15:0] MPG_IDX_DIR3 = 16'hff23;
    localparam logic [15:0] MPG_IDX_DIR6 = 16'hff26;
    localparam logic [15:0] MPG_IDX_DIR7 = 16'hff27;
    localparam logic [15:0] MPG_IDX_DIR12 = 16'hff2c;
    localparam logic [15:0] MPG_IDX_PULL0 = 16'hff30;
    localparam logic [15:0] MPG_IDX_PULL1 = 16'hff31;
    localparam logic [15:0] MPG_IDX_PULL3 = 16'hff33;
    localparam logic [15:0] MPG_IDX_PULL7 = 16'hff37;
    localparam logic [15:0] MPG_IDX_PULL12 = 16'hff3c;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MPG_DIR_RESET = 8'hff;
    localparam logic [7:0] MPG_LATCH_RESET = 8'h00;
    localparam logic [7:0] MPG_PULL_RESET = 8'h00;
    localparam logic [7:0] MPG_FULL_MASK = 8'hff;

    // ------------------------------------------------------------------
    // write data layout: byte write, or single-bit write when flagged
    // ------------------------------------------------------------------
    localparam int unsigned MPG_BITOP_POS = 15;
    localparam int unsigned MPG_BITIDX_LSB = 8;
    localparam int unsigned MPG_BITIDX_W = 3;
    localparam int unsigned MPG_BITVAL_POS = 0;

    // write strobes for one port's three registers
    typedef struct packed {
        logic dir;
        logic latch;
        logic pull;
    } mpg_wr_type;

    // merge new data into a register only where the mask is set
    function automatic logic [7:0] mpg_merge(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] mask);
        mpg_merge = (old_val & ~mask) | (new_val & mask);
    endfunction : mpg_merge

endpackage : mpg_pkg
`default_nettype wire

/* File: core/mpg_port.sv */
// one bidirectional port: direction, latch and pull-up registers with pin logic
`default_nettype none
module mpg_port
    import mpg_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter bit HAS_PULLUP = 1'b1,
    parameter bit OPEN_DRAIN = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register writes
    input wire mpg_wr_type wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] wr_mask,
    // register reads
    output logic [7:0] rd_port,
    output logic [7:0] rd_dir,
    output logic [7:0] rd_pull,
    // pins and alternate-function outputs
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] alt_out_en,
    input wire logic [WIDTH-1:0] alt_out_val,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pullup_on
);

    // bits that exist; the rest never change, so direction reads one there
    localparam logic [7:0] IMPL = MPG_FULL_MASK >> (8 - WIDTH);
    localparam logic [7:0] PULL_IMPL = HAS_PULLUP ? IMPL : 8'h00;

    logic [7:0] dir_reg, dir_next;
    logic [7:0] latch_reg, latch_next;
    logic [7:0] pull_reg, pull_next;
    logic [WIDTH-1:0] out_reg, out_next;
    logic [WIDTH-1:0] oe_reg, oe_next;
    logic [WIDTH-1:0] pullon_reg, pullon_next;

    // ------------------------------------------------------------------
    // register and pin next state
    // ------------------------------------------------------------------
    always_comb begin
        dir_next = dir_reg;
        latch_next = latch_reg;
        pull_next = pull_reg;
        if (wr_strobe.dir) begin
            dir_next = mpg_merge(dir_reg, wr_data, wr_mask & IMPL);
        end
        if (wr_strobe.latch) begin
            latch_next = mpg_merge(latch_reg, wr_data, wr_mask & IMPL);
        end
        if (wr_strobe.pull) begin
            pull_next = mpg_merge(pull_reg, wr_data, wr_mask & PULL_IMPL);
        end
        for (int i = 0; i < WIDTH; i++) begin
            // zero enables the buffer, except on an open-drain port whose latch bit is one; one leaves the pin as input
            if (OPEN_DRAIN) begin
                out_next[i] = 1'b0;
                oe_next[i] = !dir_reg[i] && !latch_reg[i];
            end else begin
                out_next[i] = alt_out_en[i] ? alt_out_val[i] : latch_reg[i];
                oe_next[i] = !dir_reg[i];
            end
            // pull-up only on an input pin not used by an alternate output
            pullon_next[i] = HAS_PULLUP && dir_reg[i] && !alt_out_en[i]
                             && pull_reg[i];
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dir_reg <= MPG_DIR_RESET;
            latch_reg <= MPG_LATCH_RESET;
            pull_reg <= MPG_PULL_RESET;
            out_reg <= '0;
            oe_reg <= '0;
            pullon_reg <= '0;
        end else begin
            dir_reg <= dir_next;
            latch_reg <= latch_next;
            pull_reg <= pull_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            pullon_reg <= pullon_next;
        end
    end

    // ------------------------------------------------------------------
    // read values: pin level for inputs, latch for outputs
    // ------------------------------------------------------------------
    always_comb begin
        rd_port = latch_reg;
        for (int i = 0; i < WIDTH; i++) begin
            rd_port[i] = dir_reg[i] ? pin_in[i] : latch_reg[i];
        end
    end

    assign rd_dir = dir_reg;
    assign rd_pull = pull_reg;
    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pullup_on = pullon_reg;

endmodule : mpg_port
`default_nettype wire

/* File: core/mpg_gpio.sv */
// top of the multi-port parallel i/o block with its avalon register slave
`default_nettype none
module mpg_gpio
    import mpg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [MPG_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [MPG_BUS_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [MPG_BUS_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // port zero
    input wire logic [1:0] p0_in,
    input wire logic [1:0] p0_alt_en,
    input wire logic [1:0] p0_alt_val,
    output logic [1:0] p0_out,
    output logic [1:0] p0_oe,
    output logic [1:0] p0_pullup,
    // port one
    input wire logic [7:0] p1_in,
    input wire logic [7:0] p1_alt_en,
    input wire logic [7:0] p1_alt_val,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [7:0] p1_pullup,
    // port two, input only
    input wire logic [7:0] p2_in,
    // port three
    input wire logic [3:0] p3_in,
    input wire logic [3:0] p3_alt_en,
    input wire logic [3:0] p3_alt_val,
    output logic [3:0] p3_out,
    output logic [3:0] p3_oe,
    output logic [3:0] p3_pullup,
    // port six, open drain
    input wire logic [3:0] p6_in,
    output logic [3:0] p6_out,
    output logic [3:0] p6_oe,
    // port seven, key return inputs
    input wire logic [3:0] p7_in,
    output logic [3:0] p7_out,
    output logic [3:0] p7_oe,
    output logic [3:0] p7_pullup,
    // port twelve, interrupt input
    input wire logic p12_in,
    output logic p12_out,
    output logic p12_oe,
    output logic p12_pullup,
    // port thirteen, output only
    output logic output_only_pin
);

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    logic wait_reg, wait_next;
    logic [MPG_BUS_W-1:0] rdata_reg, rdata_next;
    logic [7:0] latch13_reg, latch13_next;
    logic pin13_reg, pin13_next;

    logic [MPG_IDX_W-1:0] idx;
    logic req;
    logic commit;
    logic bitop;
    logic [7:0] wmask;
    logic [7:0] wdata;
    mpg_wr_type wr0, wr1, wr3, wr6, wr7, wr12;
    logic wr13;
    logic [7:0] port0_rd, port1_rd, port3_rd, port6_rd, port7_rd, port12_rd;
    logic [7:0] port0_direction, port1_direction, port3_direction;
    logic [7:0] port6_direction, port7_direction, port12_direction;
    logic [7:0] port0_pullup_enable, port1_pullup_enable, port3_pullup_enable;
    logic [7:0] port7_pullup_enable, port12_pullup_enable;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    // a request is answered one cycle after it is seen; the write lands on
    // the edge that ends the transfer so reads see state before it
    assign idx = avs_address[MPG_ADDR_W-1:2];
    assign req = avs_read || avs_write;
    assign commit = avs_write && !wait_reg && avs_byteenable[0];
    assign bitop = avs_byteenable[1] && avs_writedata[MPG_BITOP_POS];

    // single-bit write touches one bit, byte write touches all
    always_comb begin
        wmask = MPG_FULL_MASK;
        wdata = avs_writedata[7:0];
        if (bitop) begin
            wmask = 8'h01 << avs_writedata[MPG_BITIDX_LSB +: MPG_BITIDX_W];
            wdata = {8{avs_writedata[MPG_BITVAL_POS]}};
        end
    end

    // write strobes per register; unmapped addresses get none
    always_comb begin
        wr0 = '0;
        wr1 = '0;
        wr3 = '0;
        wr6 = '0;
        wr7 = '0;
        wr12 = '0;
        wr13 = 1'b0;
        if (commit) begin
            case (idx)
                MPG_IDX_LATCH0: wr0.latch = 1'b1;
                MPG_IDX_LATCH1: wr1.latch = 1'b1;
                MPG_IDX_LATCH3: wr3.latch = 1'b1;
                MPG_IDX_LATCH6: wr6.latch = 1'b1;
                MPG_IDX_LATCH7: wr7.latch = 1'b1;
                MPG_IDX_LATCH12: wr12.latch = 1'b1;
                MPG_IDX_LATCH13: wr13 = 1'b1;
                MPG_IDX_DIR0: wr0.dir = 1'b1;
                MPG_IDX_DIR1: wr1.dir = 1'b1;
                MPG_IDX_DIR3: wr3.dir = 1'b1;
                MPG_IDX_DIR6: wr6.dir = 1'b1;
                MPG_IDX_DIR7: wr7.dir = 1'b1;
                MPG_IDX_DIR12: wr12.dir = 1'b1;
                MPG_IDX_PULL0: wr0.pull = 1'b1;
                MPG_IDX_PULL1: wr1.pull = 1'b1;
                MPG_IDX_PULL3: wr3.pull = 1'b1;
                MPG_IDX_PULL7: wr7.pull = 1'b1;
                MPG_IDX_PULL12: wr12.pull = 1'b1;
                default: wr13 = 1'b0;
            endcase
        end
    end

    // read multiplexer; unmapped addresses, such as the input-only port's
    // missing direction and pull-up registers, read as zero
    always_comb begin
        case (idx)
            MPG_IDX_LATCH0: rd_byte = port0_rd;
            MPG_IDX_LATCH1: rd_byte = port1_rd;
            MPG_IDX_INPUT2: rd_byte = p2_in;
            MPG_IDX_LATCH3: rd_byte = port3_rd;
            MPG_IDX_LATCH6: rd_byte = port6_rd;
            MPG_IDX_LATCH7: rd_byte = port7_rd;
            MPG_IDX_LATCH12: rd_byte = port12_rd;
            MPG_IDX_LATCH13: rd_byte = latch13_reg;
            MPG_IDX_DIR0: rd_byte = port0_direction;
            MPG_IDX_DIR1: rd_byte = port1_direction;
            MPG_IDX_DIR3: rd_byte = port3_direction;
            MPG_IDX_DIR6: rd_byte = port6_direction;
            MPG_IDX_DIR7: rd_byte = port7_direction;
            MPG_IDX_DIR12: rd_byte = port12_direction;
            MPG_IDX_PULL0: rd_byte = port0_pullup_enable;
            MPG_IDX_PULL1: rd_byte = port1_pullup_enable;
            MPG_IDX_PULL3: rd_byte = port3_pullup_enable;
            MPG_IDX_PULL7: rd_byte = port7_pullup_enable;
            MPG_IDX_PULL12: rd_byte = port12_pullup_enable;
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // bus handshake and port thirteen next state
    // ------------------------------------------------------------------
    always_comb begin
        wait_next = !(req && wait_reg);
        rdata_next = rdata_reg;
        if (avs_read && wait_reg) begin
            rdata_next = {24'h000000, rd_byte};
        end
        latch13_next = latch13_reg;
        if (wr13) begin
            latch13_next = mpg_merge(latch13_reg, wdata, wmask & 8'h01);
        end
        pin13_next = latch13_reg[0];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
            latch13_reg <= MPG_LATCH_RESET;
            pin13_reg <= 1'b0;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            latch13_reg <= latch13_next;
            pin13_reg <= pin13_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign output_only_pin = pin13_reg;

    // ------------------------------------------------------------------
    // bidirectional ports
    // ------------------------------------------------------------------
    // alternate peripherals read the pins directly; their direction and
    // latch setup is left to software
    mpg_port #(.WIDTH(2), .HAS_PULLUP(1'b1), .OPEN_DRAIN(1'b0)) u_port0 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_strobe(wr0),
        .wr_data(wdata),
        .wr_mask(wmask),
        .rd_port(port0_rd),
        .rd_dir(port0_direction),
        .rd_pull(port0_pullup_enable),
        .pin_in(p0_in),
        .alt_out_en(p0_alt_en),
        .alt_out_val(p0_alt_val),
        .pin_out(p0_out),
        .pin_oe(p0_oe),
        .pullup_on(p0_pullup)
    );

    mpg_port #(.WIDTH(8), .HAS_PULLUP(1'b1), .OPEN_DRAIN(1'b0)) u_port1 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_strobe(wr1),
        .wr_data(wdata),
        .wr_mask(wmask),
        .rd_port(port1_rd),
        .rd_dir(port1_direction),
        .rd_pull(port1_pullup_enable),
        .pin_in(p1_in),
        .alt_out_en(p1_alt_en),
        .alt_out_val(p1_alt_val),
        .pin_out(p1_out),
        .pin_oe(p1_oe),
        .pullup_on(p1_pullup)
    );

    mpg_port #(.WIDTH(4), .HAS_PULLUP(1'b1), .OPEN_DRAIN(1'b0)) u_port3 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_strobe(wr3),
        .wr_data(wdata),
        .wr_mask(wmask),
        .rd_port(port3_rd),
        .rd_dir(port3_direction),
        .rd_pull(port3_pullup_enable),
        .pin_in(p3_in),
        .alt_out_en(p3_alt_en),
        .alt_out_val(p3_alt_val),
        .pin_out(p3_out),
        .pin_oe(p3_oe),
        .pullup_on(p3_pullup)
    );

    // pull-up on these pins is a manufacturing option, outside this logic
    mpg_port #(.WIDTH(4), .HAS_PULLUP(1'b0), .OPEN_DRAIN(1'b1)) u_port6 (
        .clk_sys(clk_sys), .rst_b(rst_b), .wr_strobe(wr6), .wr_data(wdata),
        .wr_mask(wmask), .rd_port(port6_rd), .rd_dir(port6_direction),
        .rd_pull(), .pin_in(p6_in), .alt_out_en(4'h0),
        .alt_out_val(4'h0), .pin_out(p6_out), .pin_oe(p6_oe),
        .pullup_on()
    );

    mpg_port #(.WIDTH(4), .HAS_PULLUP(1'b1), .OPEN_DRAIN(1'b0)) u_port7 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr_strobe(wr7),
        .wr_data(wdata),
        .wr_mask(wmask),
        .rd_port(port7_rd),
        .rd_dir(port7_direction),
        .rd_pull(port7_pullup_enable),
        .pin_in(p7_in),
        .alt_out_en(4'h0),
        .alt_out_val(4'h0),
        .pin_out(p7_out),
        .pin_oe(p7_oe),
        .pullup_on(p7_pullup)
    );

    mpg_port #(.WIDTH(1), .HAS_PULLUP(1'b1), .OPEN_DRAIN(1'b0)) u_port12 (
        .clk_sys(clk_sys), .rst_b(rst_b), .wr_strobe(wr12), .wr_data(wdata),
        .wr_mask(wmask), .rd_port(port12_rd), .rd_dir(port12_direction),
        .rd_pull(port12_pullup_enable), .pin_in(p12_in), .alt_out_en(1'b0),
        .alt_out_val(1'b0), .pin_out(p12_out), .pin_oe(p12_oe),
        .pullup_on(p12_pullup)
    );

endmodule : mpg_gpio
`default_nettype wire

/* File: verification/mpg_gpio_monitor.sv */
// bus and pin assertions for the multi-port parallel i/o block
`default_nettype none
module mpg_gpio_monitor
    import mpg_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire logic [MPG_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [MPG_BUS_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire logic [7:0] p1_oe,
    input wire logic [7:0] p1_pullup,
    input wire logic [7:0] p2_in,
    input wire logic [3:0] p6_out,
    input wire logic [3:0] p7_oe,
    input wire logic [3:0] p7_pullup,
    input wire logic output_only_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // one clock domain, so clock and disable are stated once
    // ------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    ack_two_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered on the next edge");
    ack_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("answer without a request");
    // the input-only port reads the level seen at the taking edge
    rd_port2_a: assert property (!avs_waitrequest && avs_read
        && avs_address == {MPG_IDX_INPUT2, 2'b00} |-> avs_readdata == {24'h0, $past(p2_in)})
        else $error("input-only port read wrong");
    od_drive_a: assert property (p6_out == 4'h0)
        else $error("open-drain pin driven high");
    pull_out_a: assert property ((p1_pullup & p1_oe) == 8'h0 && (p7_pullup & p7_oe) == 4'h0)
        else $error("pull-up on an output pin");
    // pin enables move only two edges after a completed write
    oe_cause_a: assert property ($changed(p1_oe)
        |-> $past(avs_write, 2) && !$past(avs_waitrequest, 2))
        else $error("output enable changed without a write");
    pin13_cause_a: assert property ($changed(output_only_pin)
        |-> $past(avs_write, 2) && !$past(avs_waitrequest, 2))
        else $error("output-only pin changed without a write");
    rst_quiet_a: assert property ($rose(rst_b)
        |-> avs_waitrequest && p1_oe == 8'h0 && !output_only_pin)
        else $error("state after reset wrong");

    cover property (!avs_waitrequest && avs_write);
    cover property (p1_pullup != 8'h0);
    cover property ($rose(output_only_pin));
endmodule : mpg_gpio_monitor
`default_nettype wire

/* File: verification/mpg_pin_model.sv */
// pad model: resolves one port's pins from the block, pull-ups and far devices
`default_nettype none
module mpg_pin_model #(
    parameter int unsigned W = 8
) (
    // block side
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    // far side: level driven, and which pins it has released
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] rel,
    // resolved level
    output logic [W-1:0] lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // far device drives input pins and lets go where the block drives;
    // a floating pin without pull-up shows the inverse of the far device's level
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = oe[i] ? out[i] : (rel[i] ? (pu[i] | ~ext[i]) : ext[i]);
        end
    end
endmodule : mpg_pin_model
`default_nettype wire

/* File: verification/mpg_gpio_tb.sv */
// self-checking bench for the multi-port parallel i/o block
`default_nettype none
module mpg_gpio_tb
    import mpg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [MPG_ADDR_W-1:0] avs_address;
    logic [MPG_BUS_W-1:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [1:0] p0_in, p0_alt_en, p0_alt_val, p0_out, p0_oe, p0_pullup;
    logic [7:0] p1_in, p1_alt_en, p1_alt_val, p1_out, p1_oe, p1_pullup, p2_in, x1, r1;
    logic [3:0] p3_in, p3_alt_en, p3_alt_val, p3_out, p3_oe, p3_pullup;
    logic [3:0] p6_in, p6_out, p6_oe, p7_in, p7_out, p7_oe, p7_pullup, x6, r6, x7, r7;
    logic p12_in, p12_out, p12_oe, p12_pullup, output_only_pin;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    mpg_gpio dut (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .p0_in, .p0_alt_en, .p0_alt_val,
        .p0_out, .p0_oe, .p0_pullup, .p1_in, .p1_alt_en, .p1_alt_val, .p1_out, .p1_oe,
        .p1_pullup, .p2_in, .p3_in, .p3_alt_en, .p3_alt_val, .p3_out, .p3_oe, .p3_pullup,
        .p6_in, .p6_out, .p6_oe, .p7_in, .p7_out, .p7_oe, .p7_pullup, .p12_in, .p12_out,
        .p12_oe, .p12_pullup, .output_only_pin);
    mpg_pin_model #(.W(8)) pm1 (.out(p1_out), .oe(p1_oe), .pu(p1_pullup), .ext(x1),
        .rel(r1), .lvl(p1_in));
    mpg_pin_model #(.W(4)) pm6 (.out(p6_out), .oe(p6_oe), .pu(4'h0), .ext(x6),
        .rel(r6), .lvl(p6_in));
    mpg_pin_model #(.W(4)) pm7 (.out(p7_out), .oe(p7_oe), .pu(p7_pullup), .ext(x7),
        .rel(r7), .lvl(p7_in));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ------------
    // shared bus cycle and compare tasks
    // ------------
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        bus(1'b1, idx, {24'h0, v}, 4'h1);
    endtask : wr
    task automatic rdc(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h0, 4'h0);
        chk(nm, rd[7:0], exp);
    endtask : rdc
    // pins lag the register by one edge
    task automatic settle;
        repeat (2) @(negedge clk_sys);
    endtask : settle
    task automatic conclude;
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // ------------
    // scenarios
    // ------------
    task automatic t_reset;
        logic [15:0] dirs [6] = '{16'hff20, 16'hff21, 16'hff23, 16'hff26, 16'hff27, 16'hff2c};
        logic [15:0] puls [5] = '{16'hff30, 16'hff31, 16'hff33, 16'hff37, 16'hff3c};
        foreach (dirs[i]) rdc("dir", dirs[i], 8'hff);
        foreach (puls[i]) rdc("pull", puls[i], 8'h00);
        chk("p1_oe_rst", p1_oe, 8'h00);
    endtask : t_reset
    // port one pins stay general except bit 7, which the test switches to its alternate output
    task automatic t_port1;
        wr(MPG_IDX_DIR1, 8'h00);
        rdc("latch1", MPG_IDX_LATCH1, 8'h00);
        wr(MPG_IDX_LATCH1, 8'ha5);
        wr(MPG_IDX_DIR1, 8'h0f);
        settle();
        chk("p1_oe", p1_oe, 8'hf0);
        chk("p1_out", p1_out, 8'ha5);
        rdc("port1", MPG_IDX_LATCH1, 8'hac);
        wr(MPG_IDX_PULL1, 8'hff);
        r1 <= 8'hff;
        p1_alt_en <= 8'h80;
        settle();
        chk("p1_pullup", p1_pullup, 8'h0f);
        chk("p1_alt", p1_out, 8'h25);
        rdc("port1_pu", MPG_IDX_LATCH1, 8'haf);
    endtask : t_port1
    task automatic t_bits;
        wr(MPG_IDX_PULL12, 8'h01);
        settle();
        chk("p12_pullup", 8'(p12_pullup), 8'h01);
        bus(1'b1, MPG_IDX_DIR12, 32'h8000, 4'h3);
        bus(1'b1, MPG_IDX_DIR0, 32'h8100, 4'h3);
        settle();
        chk("p12_oe", 8'({p12_oe, p12_pullup}), 8'h02);
        rdc("dir0_bit", MPG_IDX_DIR0, 8'hfd);
        wr(MPG_IDX_DIR0, 8'h00);
        rdc("dir0_byte", MPG_IDX_DIR0, 8'hfc);
        chk("p0_oe", 8'(p0_oe), 8'h03);
        wr(MPG_IDX_LATCH0, 8'h02);
        wr(MPG_IDX_LATCH12, 8'h01);
        settle();
        chk("p0_p12_pins", 8'({p0_out, p0_pullup, p12_out, p12_oe}), 8'h23);
    endtask : t_bits
    task automatic t_misc;
        wr(MPG_IDX_LATCH6, 8'h05);
        wr(MPG_IDX_DIR6, 8'h00);
        settle();
        chk("p6_drive", {p6_oe, p6_out}, 8'ha0);
        rdc("port6", MPG_IDX_LATCH6, 8'h05);
        wr(16'hff36, 8'hff);
        rdc("pull6", 16'hff36, 8'h00);
        rdc("port7", MPG_IDX_LATCH7, 8'h00);
        wr(MPG_IDX_PULL7, 8'h0f);
        settle();
        chk("p7_pullup", 8'(p7_pullup), 8'h0f);
        rdc("port7_pu", MPG_IDX_LATCH7, 8'h0f);
        wr(MPG_IDX_LATCH7, 8'h09);
        wr(MPG_IDX_DIR7, 8'h0c);
        settle();
        chk("p7_pins", {p7_out, p7_oe}, 8'h93);
        chk("p7_pu_out", 8'(p7_pullup), 8'h0c);
        p2_in <= 8'h5a;
        wr(MPG_IDX_INPUT2, 8'h00);
        rdc("port2", MPG_IDX_INPUT2, 8'h5a);
        p3_alt_en <= 4'h1;
        p3_alt_val <= 4'h1;
        wr(MPG_IDX_PULL3, 8'h0f);
        wr(MPG_IDX_DIR3, 8'hf0);
        settle();
        chk("p3_pins", {p3_out, p3_pullup}, 8'h10);
        chk("p3_oe", 8'(p3_oe), 8'h0f);
    endtask : t_misc
    task automatic t_p13;
        wr(MPG_IDX_LATCH13, 8'h01);
        settle();
        chk("pin13", 8'(output_only_pin), 8'h01);
        // reset moves on a rising edge and spans two edges so rst_quiet_a sees its release
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(negedge clk_sys);
        chk("pin13_rst", 8'(output_only_pin), 8'h00);
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdc("dir1_rst", MPG_IDX_DIR1, 8'hff);
        bus(1'b1, MPG_IDX_DIR1, 32'h0, 4'h2);
        rdc("dir1_no_be0", MPG_IDX_DIR1, 8'hff);
    endtask : t_p13

    // watchdog: the whole sequence needs well under this many cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        rst_b = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {p0_in, p0_alt_en, p0_alt_val, p1_alt_en, p1_alt_val, p2_in} = '0;
        {p3_in, p3_alt_en, p3_alt_val, p12_in, r1, x6, r6} = '0;
        x1 = 8'h3c;
        x7 = 4'hf;
        r7 = 4'hf;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_port1();
        t_bits();
        t_misc();
        t_p13();
        conclude();
    end
endmodule : mpg_gpio_tb

bind mpg_gpio mpg_gpio_monitor mon (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .p1_oe, .p1_pullup, .p2_in, .p6_out, .p7_oe,
    .p7_pullup, .output_only_pin);
`default_nettype wire
